// ===== inc/scs_pkg.sv
// Constants, types and register map of the sample clock and output update block.
package scs_pkg;
  localparam int REF_MHZ = 50;
  localparam int REF_HZ = 50_000_000;
  localparam int MCLK_HZ = 30_000_000;
  localparam int HZ_GCD = 10_000_000;
  localparam logic [2:0] MCLK_INC = 3'(MCLK_HZ / HZ_GCD);
  localparam logic [2:0] MCLK_MOD = 3'(REF_HZ / HZ_GCD);
  localparam int TUNE_BASE_MHZ = 16;
  localparam int TUNE_DEN = 511;
  localparam logic [15:0] TUNE_MOD = 16'(TUNE_DEN * REF_MHZ);
  localparam int NCH = 12;
  localparam int DW = 16;
  localparam int WW = 17;
  localparam int FIFO_DEPTH = 32;
  localparam logic [3:0] LAST_CH = 4'(NCH - 1);
  localparam logic [4:0] LAST_HALF = 5'h1F;
  // Register byte offsets.
  localparam logic [4:0] OFS_BCR = 5'h00;
  localparam logic [4:0] OFS_CHSEL = 5'h04;
  localparam logic [4:0] OFS_RATE = 5'h08;
  localparam logic [4:0] OFS_BOPS = 5'h0C;
  localparam logic [4:0] OFS_DATA = 5'h18;
  localparam logic [4:0] OFS_TUNE = 5'h1C;
  // Field positions.
  localparam int BCR_SIMUL = 7;
  localparam int BCR_INIT = 15;
  localparam int BOPS_EXT = 4;
  localparam int BOPS_EN = 5;
  localparam int BOPS_RDY = 6;
  localparam int BOPS_SWCLK = 7;
  localparam int BOPS_CLR = 11;
  localparam int BOPS_EMPTY = 12;
  localparam int BOPS_FULL = 15;
  localparam int TUNE_INIT_BIT = 9;
  // Reset values.
  localparam logic [15:0] BCR_RST = 16'h0810;
  localparam logic [11:0] CHSEL_RST = 12'hFFF;
  localparam logic [15:0] RATE_RST = 16'h004B;
  localparam logic [9:0] BOPS_RST = 10'h00D;
  localparam logic [9:0] TUNE_RST = 10'h000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_UPD = 4'b1000
  } scs_state_e;
  typedef enum logic [2:0] {
    SRC_OFF = 3'b001,
    SRC_INT = 3'b010,
    SRC_EXT = 3'b100
  } scs_src_e;
  typedef struct packed {
    logic eof;
    logic [DW-1:0] data;
  } scs_word_s;
endpackage

// ===== rtl/scs_sample_clock.sv
// Sample clock sources, multiboard clock pair and per-channel converter update sequencer.
`timescale 1ns/100ps

// -----------------------------------------------------------------
// Sample FIFO
// -----------------------------------------------------------------
module scs_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clr,
  // Fill side
  input wire logic in_valid,
  output logic in_ready_q,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign push = in_valid && in_ready_q;
  assign pop = out_valid && out_ready;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || clr) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b1;
    end else begin
      wp_q <= push ? wp_q + AW'(1) : wp_q;
      rp_q <= pop ? rp_q + AW'(1) : rp_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      in_ready_q <= (cnt_q + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
    end
  end
endmodule

// -----------------------------------------------------------------
// Top
// -----------------------------------------------------------------
module scs_sample_clock import scs_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Local register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  output logic buf_wready_q,
  // Differential synchronization clock pair
  input wire logic clk_io_in,
  output logic clk_io_p_q,
  output logic clk_io_n_q,
  output logic clk_io_oe_q,
  // Converter serial links
  output logic dac_sclk_q,
  output logic dac_sdi_q,
  output logic [NCH-1:0] dac_sel_q,
  output logic [NCH-1:0] dac_ldac_q,
  // Output clock connector pin and frame marker
  output logic out_clk_q,
  output logic frame_eof_q
);
  logic [15:0] bcr_q;
  logic [NCH-1:0] chsel_q;
  logic [15:0] rate_q;
  logic [9:0] bops_q;
  logic [9:0] tune_q;
  logic init_q;
  logic clr_q;
  logic wr_bcr;
  logic wr_bops;
  logic push;
  scs_state_e st_q;
  scs_src_e src_q;
  scs_src_e src_d;
  scs_word_s fifo_word;
  logic fifo_valid;
  logic pop;

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  assign wr_bcr = reg_wr && reg_addr == OFS_BCR;
  assign wr_bops = reg_wr && reg_addr == OFS_BOPS;
  assign push = reg_wr && reg_addr == OFS_DATA && buf_wready_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      init_q <= 1'b0;
    end else begin
      init_q <= wr_bcr && reg_wdata[BCR_INIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || init_q) begin
      bcr_q <= BCR_RST;
      chsel_q <= CHSEL_RST;
      rate_q <= RATE_RST;
    end else begin
      if (wr_bcr) begin
        bcr_q <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == OFS_CHSEL) begin
        chsel_q <= reg_wdata[NCH-1:0];
      end
      if (reg_wr && reg_addr == OFS_RATE) begin
        rate_q <= reg_wdata[15:0];
      end
    end
  end

  // The software clock bit lives one cycle, so it yields exactly one tick.
  always_ff @(posedge ref_clk) begin
    if (rst || init_q) begin
      bops_q <= BOPS_RST;
      clr_q <= 1'b0;
    end else begin
      clr_q <= wr_bops && reg_wdata[BOPS_CLR];
      if (wr_bops) begin
        bops_q <= reg_wdata[9:0];
      end else begin
        bops_q[BOPS_SWCLK] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tune_q <= TUNE_RST;
    end else if (init_q) begin
      tune_q[TUNE_INIT_BIT] <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_TUNE) begin
      tune_q <= reg_wdata[9:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_BCR: reg_rdata_q <= {16'h0000, init_q, 1'b0, bcr_q[13:2], st_q == ST_IDLE, bcr_q[0]};
        OFS_CHSEL: reg_rdata_q <= {20'h00000, chsel_q};
        OFS_RATE: reg_rdata_q <= {16'h0000, rate_q};
        OFS_BOPS: reg_rdata_q <= {16'h0000, !buf_wready_q, 2'b00, !fifo_valid, clr_q, 1'b0,
                                  bops_q[9:7], st_q == ST_IDLE && bops_q[BOPS_EXT], bops_q[5:0]};
        OFS_TUNE: reg_rdata_q <= {22'h000000, tune_q};
        default: reg_rdata_q <= '0;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Clock sources
  // -----------------------------------------------------------------
  logic [2:0] mclk_acc_q;
  logic mclk_tick;
  logic [15:0] tune_acc_q;
  logic [15:0] tune_inc;
  logic [15:0] tune_sum;
  logic tune_tick;
  logic initiator;
  logic pin_m_q;
  logic pin_s_q;
  logic pin_d_q;
  logic ext_tick;

  assign initiator = tune_q[TUNE_INIT_BIT];
  // Fixed 30 MHz master clock as an enable: accumulate 3 modulo 5 per 50 MHz cycle.
  assign mclk_tick = (mclk_acc_q + MCLK_INC) >= MCLK_MOD;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mclk_acc_q <= '0;
    end else begin
      mclk_acc_q <= mclk_tick ? mclk_acc_q + MCLK_INC - MCLK_MOD : mclk_acc_q + MCLK_INC;
    end
  end

  // Exact rate: ticks/s = 50e6 * 16*(511+N) / (511*50) = 16e6*(1+N/511).
  assign tune_inc = 16'(TUNE_BASE_MHZ * (TUNE_DEN + int'(tune_q[8:0])));
  assign tune_sum = tune_acc_q + tune_inc;
  assign tune_tick = tune_sum >= TUNE_MOD;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tune_acc_q <= '0;
    end else begin
      tune_acc_q <= tune_tick ? tune_sum - TUNE_MOD : tune_sum;
    end
  end

  // The pair carries one reference-cycle pulse per tunable period; a 50 MHz
  // reference cannot make a true square wave above 25 MHz.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_io_p_q <= 1'b0;
      clk_io_n_q <= 1'b1;
      clk_io_oe_q <= 1'b0;
    end else begin
      clk_io_p_q <= initiator && tune_tick;
      clk_io_n_q <= !(initiator && tune_tick);
      clk_io_oe_q <= initiator;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_m_q <= 1'b0;
      pin_s_q <= 1'b0;
      pin_d_q <= 1'b0;
    end else begin
      pin_m_q <= clk_io_in;
      pin_s_q <= pin_m_q;
      pin_d_q <= pin_s_q;
    end
  end

  assign ext_tick = (pin_s_q && !pin_d_q && !initiator) || bops_q[BOPS_SWCLK];

  // -----------------------------------------------------------------
  // Rate generator and source selection
  // -----------------------------------------------------------------
  logic [15:0] rate_cnt_q;
  logic base_tick;
  logic int_tick;
  logic switching;
  logic sample_tick;

  assign base_tick = initiator ? tune_tick : mclk_tick;
  assign int_tick = base_tick && rate_cnt_q <= 16'h0001;

  always_comb begin
    if (!bops_q[BOPS_EN]) begin
      src_d = SRC_OFF;
    end else if (bops_q[BOPS_EXT]) begin
      src_d = SRC_EXT;
    end else begin
      src_d = SRC_INT;
    end
  end

  // A changeover costs one blanked cycle and restarts the divisor count.
  assign switching = src_d != src_q;
  assign sample_tick = !switching && ((src_q == SRC_INT && int_tick) ||
                                      (src_q == SRC_EXT && ext_tick));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      src_q <= SRC_OFF;
    end else begin
      src_q <= src_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || switching) begin
      rate_cnt_q <= rate_q;
    end else if (base_tick) begin
      rate_cnt_q <= int_tick ? rate_q : rate_cnt_q - 16'h0001;
    end
  end

  // -----------------------------------------------------------------
  // Sample buffer
  // -----------------------------------------------------------------
  logic [WW-1:0] fifo_out;

  scs_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(clr_q || init_q),
    .in_valid(push),
    .in_ready_q(buf_wready_q),
    .in_data(reg_wdata[WW-1:0]),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_out)
  );

  assign fifo_word = fifo_out;

  // -----------------------------------------------------------------
  // Converter update sequencer
  // -----------------------------------------------------------------
  logic [3:0] ch_q;
  logic [4:0] half_q;
  logic [DW-1:0] sh_q;
  logic eof_q;
  logic ch_on;

  assign ch_on = chsel_q[ch_q];
  assign pop = st_q == ST_FETCH && ch_on && fifo_valid;

  always_ff @(posedge ref_clk) begin
    if (rst || init_q) begin
      st_q <= ST_IDLE;
      ch_q <= '0;
      half_q <= '0;
      sh_q <= '0;
      eof_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          ch_q <= '0;
          eof_q <= 1'b0;
          if (sample_tick && |chsel_q) begin
            st_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          half_q <= '0;
          if (pop) begin
            sh_q <= fifo_word.data;
            eof_q <= eof_q | fifo_word.eof;
            st_q <= ST_SHIFT;
          end else if (!ch_on) begin
            ch_q <= ch_q + 4'h1;
            st_q <= ch_q == LAST_CH ? ST_UPD : ST_FETCH;
          end
        end
        ST_SHIFT: begin
          half_q <= half_q + 5'h01;
          if (half_q[0]) begin
            sh_q <= {sh_q[DW-2:0], 1'b0};
          end
          if (half_q == LAST_HALF) begin
            ch_q <= ch_q + 4'h1;
            st_q <= ch_q == LAST_CH ? ST_UPD : ST_FETCH;
          end
        end
        ST_UPD: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || init_q) begin
      dac_sclk_q <= 1'b0;
      dac_sdi_q <= 1'b0;
      dac_sel_q <= '0;
    end else begin
      dac_sclk_q <= st_q == ST_SHIFT && !half_q[0];
      dac_sdi_q <= st_q == ST_SHIFT && sh_q[DW-1];
      dac_sel_q <= '0;
      if (st_q == ST_SHIFT) begin
        dac_sel_q[ch_q] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || init_q) begin
      dac_ldac_q <= '0;
      out_clk_q <= 1'b0;
      frame_eof_q <= 1'b0;
    end else begin
      dac_ldac_q <= '0;
      if (st_q == ST_SHIFT && half_q == LAST_HALF && !bcr_q[BCR_SIMUL]) begin
        dac_ldac_q[ch_q] <= 1'b1;
      end
      if (st_q == ST_UPD && bcr_q[BCR_SIMUL]) begin
        dac_ldac_q <= chsel_q;
      end
      out_clk_q <= st_q == ST_UPD;
      frame_eof_q <= st_q == ST_UPD && eof_q;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_init_target;
    init_q |=> !tune_q[TUNE_INIT_BIT];
  endproperty
  a_init_target: assert property (p_init_target) else $error("init left initiator set");

  property p_init_freq;
    init_q |=> $stable(tune_q[8:0]);
  endproperty
  a_init_freq: assert property (p_init_freq) else $error("init changed tunable field");

  property p_pair_dir;
    !$past(initiator) |-> !clk_io_oe_q && !clk_io_p_q;
  endproperty
  a_pair_dir: assert property (p_pair_dir) else $error("pair driven in target mode");

  property p_out_clk;
    out_clk_q |-> $past(st_q) == ST_UPD ##1 !out_clk_q;
  endproperty
  a_out_clk: assert property (p_out_clk) else $error("output clock pulse not tied to update");

  property p_simul;
    $past(st_q) == ST_UPD && $past(bcr_q[BCR_SIMUL]) && !$past(init_q) |-> dac_ldac_q == $past(chsel_q);
  endproperty
  a_simul: assert property (p_simul) else $error("simultaneous update missed channels");

  property p_seq;
    !$past(bcr_q[BCR_SIMUL]) |-> $onehot0(dac_ldac_q);
  endproperty
  a_seq: assert property (p_seq) else $error("sequential update hit several channels");

  property p_stop;
    !bops_q[BOPS_EN] && st_q == ST_IDLE |-> !sample_tick ##1 st_q == ST_IDLE && !out_clk_q;
  endproperty
  a_stop: assert property (p_stop) else $error("sample tick while clocking disabled");

  property p_switch;
    switching |-> !sample_tick ##1 rate_cnt_q == $past(rate_q);
  endproperty
  a_switch: assert property (p_switch) else $error("tick during source changeover");

  property p_shift;
    pop |=> (st_q == ST_SHIFT && $onehot(dac_sel_q) == 1'b0) ##1 (st_q == ST_SHIFT && $onehot(dac_sel_q))[*8];
  endproperty
  a_shift: assert property (p_shift) else $error("serial shift cut short");

  property p_rate;
    int_tick && src_q == SRC_INT && !switching |=> rate_cnt_q == $past(rate_q);
  endproperty
  a_rate: assert property (p_rate) else $error("rate counter did not reload");

  c_simul: cover property (st_q == ST_UPD && bcr_q[BCR_SIMUL] && |chsel_q);
  c_seq: cover property (|dac_ldac_q && !bcr_q[BCR_SIMUL]);
  c_init_tick: cover property (initiator && sample_tick);
  c_ext_tick: cover property (src_q == SRC_EXT && sample_tick);
endmodule

// ===== dv/scs_sync_peer.sv
// Model of a neighbouring board that shares the differential synchronization clock pair.
`timescale 1ns/100ps

// ---------------------------------------------
// Peer board
// ---------------------------------------------
module scs_sync_peer #(
  parameter int HALF_NS = 1500
) (
  // Control from the bench
  input wire logic run,
  // Pair as driven by the device
  input wire logic dev_oe,
  input wire logic dev_p,
  // Resolved pair level and count of produced rising edges
  output logic pair_lvl,
  output int edge_n
);
  logic clk_q = 1'b0;

  initial edge_n = 0;

  // The peer clock runs only while the bench asks for it and stands low between bursts.
  always begin
    #(HALF_NS);
    if (run) begin
      clk_q = ~clk_q;
      if (clk_q) edge_n++;
    end else begin
      clk_q = 1'b0;
    end
  end

  // The peer lets go of the pair whenever the device drives it as initiator.
  assign pair_lvl = dev_oe ? dev_p : clk_q;
endmodule

// ===== dv/scs_sample_clock_tb.sv
// Self-checking testbench of the sample clock and output update block.
`timescale 1ns/100ps

module scs_sample_clock_tb import scs_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata_q;
  logic buf_wready_q, clk_io_in, clk_io_p_q, clk_io_n_q, clk_io_oe_q;
  logic dac_sclk_q, dac_sdi_q, out_clk_q, frame_eof_q;
  logic [NCH-1:0] dac_sel_q, dac_ldac_q;
  logic [31:0] sh = 32'h0000_0000;
  logic [NCH-1:0] lq[$];
  logic [NCH-1:0] sel_or = '0;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int last = 0;
  int ival = 0;
  int oc_n = 0;
  int eof_n = 0;
  int pc = 0;
  int base = 0;
  int pe = 0;
  int edge_n;

  always #10 ref_clk = ~ref_clk;

  scs_sample_clock u_scs_sample_clock (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_q, .buf_wready_q, .clk_io_in, .clk_io_p_q, .clk_io_n_q, .clk_io_oe_q, .dac_sclk_q,
    .dac_sdi_q, .dac_sel_q, .dac_ldac_q, .out_clk_q, .frame_eof_q);

  scs_sync_peer u_scs_sync_peer (.run, .dev_oe(clk_io_oe_q), .dev_p(clk_io_p_q), .pair_lvl(clk_io_in),
    .edge_n);

  // ---------------------------------------------
  // Verdict and port monitor
  // ---------------------------------------------
  task summarize;
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Serial data is taken while the serial clock is high, so every bit is seen once.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
    if (clk_io_p_q === 1'b1) pc++;
    if (out_clk_q === 1'b1) begin
      oc_n++;
      ival = cyc - last;
      last = cyc;
    end
    if (frame_eof_q === 1'b1) eof_n++;
    if (dac_ldac_q != '0) lq.push_back(dac_ldac_q);
    if (dac_sclk_q === 1'b1 && dac_sel_q != '0) sh = {sh[30:0], dac_sdi_q};
    if (!rst) begin
      sel_or = sel_or | dac_sel_q;
      chk("pair complement", !clk_io_p_q, clk_io_n_q);
    end
  end

  // ---------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task rng(input string nm, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task rd(input logic [4:0] a, input logic [31:0] exp, input string nm);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(nm, exp, reg_rdata_q);
  endtask

  task cw(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task wait_oc(input int n);
    repeat (4000) if (oc_n < n) @(negedge ref_clk);
  endtask

  task words(input int n);
    repeat (n) wr(OFS_DATA, 32'h0000_1111);
  endtask

  // Three updates from the rate generator; the last gap is left in ival.
  task rate_run(input logic [31:0] r);
    wr(OFS_BOPS, 32'h0000_080D);
    wr(OFS_CHSEL, 32'h0000_0001);
    wr(OFS_RATE, r);
    words(4);
    base = oc_n;
    wr(OFS_BOPS, 32'h0000_002D);
    wait_oc(base + 3);
    wr(OFS_BOPS, 32'h0000_080D);
  endtask

  // ---------------------------------------------
  // Test sequence
  // ---------------------------------------------
  initial begin
    cw(10);
    rst = 1'b0;
    rd(OFS_BCR, 32'h0000_0812, "board control");
    rd(OFS_CHSEL, 32'h0000_0FFF, "chan select");
    rd(OFS_RATE, 32'h0000_004B, "rate");
    rd(OFS_BOPS, 32'h0000_100D, "buffer ops");
    rd(OFS_TUNE, 32'h0000_0000, "tunable");
    rd(OFS_DATA, 32'h0000_0000, "data read");
    rd(5'h10, 32'h0000_0000, "unmapped");
    words(32);
    cw(1);
    chk("write ready full", 32'h0000_0000, buf_wready_q);
    rd(OFS_BOPS, 32'h0000_800D, "buffer full");
    wr(OFS_BOPS, 32'h0000_080D);
    cw(2);
    rd(OFS_BOPS, 32'h0000_100D, "buffer cleared");
    chk("write ready empty", 32'h0000_0001, buf_wready_q);
    wr(OFS_CHSEL, 32'h0000_0005);
    wr(OFS_BCR, 32'h0000_0890);
    wr(OFS_DATA, 32'h0000_1234);
    wr(OFS_DATA, 32'h0001_A5C3);
    lq.delete();
    sel_or = '0;
    base = oc_n;
    wr(OFS_BOPS, 32'h0000_003D);
    wr(OFS_BOPS, 32'h0000_00BD);
    wait_oc(base + 1);
    cw(2);
    chk("shifted words", 32'h1234_A5C3, sh);
    chk("selects seen", 32'h0000_0005, sel_or);
    chk("update count", 32'h0000_0001, lq.size());
    chk("update lines", 32'h0000_0005, lq[0]);
    chk("out clock pulses", base + 1, oc_n);
    chk("frame end pulses", 32'h0000_0001, eof_n);
    wr(OFS_BCR, 32'h0000_0810);
    wr(OFS_CHSEL, 32'h0000_0003);
    wr(OFS_DATA, 32'h0000_0001);
    wr(OFS_DATA, 32'h0000_8000);
    lq.delete();
    sel_or = '0;
    base = oc_n;
    wr(OFS_BOPS, 32'h0000_00BD);
    wait_oc(base + 1);
    cw(2);
    chk("shifted words seq", 32'h0001_8000, sh);
    chk("selects seen seq", 32'h0000_0003, sel_or);
    chk("update count seq", 32'h0000_0002, lq.size());
    chk("first update", 32'h0000_0001, lq[0]);
    chk("second update", 32'h0000_0002, lq[1]);
    chk("out clock seq", base + 1, oc_n);
    chk("frame end seq", 32'h0000_0001, eof_n);
    wr(OFS_BOPS, 32'h0000_000D);
    words(1);
    base = oc_n;
    wr(OFS_BOPS, 32'h0000_009D);
    cw(100);
    chk("pulses while stopped", base, oc_n);
    rate_run(32'h0000_0064);
    rng("rate gap", 166, 167, ival);
    wr(OFS_TUNE, 32'h0000_0200);
    cw(3);
    chk("pair driven", 32'h0000_0001, clk_io_oe_q);
    pc = 0;
    cw(1250);
    rng("tunable pulses low", 399, 401, pc);
    wr(OFS_TUNE, 32'hFFFF_FFFF);
    rd(OFS_TUNE, 32'h0000_03FF, "tunable bits");
    pc = 0;
    cw(1250);
    rng("tunable pulses high", 799, 801, pc);
    wr(OFS_TUNE, 32'h0000_0200);
    rate_run(32'h0000_0064);
    rng("initiator rate gap", 312, 313, ival);
    wr(OFS_TUNE, 32'h0000_0264);
    wr(OFS_BCR, 32'h0000_8000);
    cw(2);
    rd(OFS_TUNE, 32'h0000_0064, "tunable after init");
    chk("pair released", 32'h0000_0000, clk_io_oe_q);
    rd(OFS_CHSEL, 32'h0000_0FFF, "chan select after init");
    wr(OFS_CHSEL, 32'h0000_0001);
    words(4);
    wr(OFS_BOPS, 32'h0000_003D);
    rd(OFS_BOPS, 32'h0000_007D, "clock ready");
    base = oc_n;
    pe = edge_n;
    run = 1'b1;
    cw(500);
    run = 1'b0;
    cw(200);
    rng("peer edges", 2, 4, edge_n - pe);
    chk("pair clock updates", edge_n - pe, oc_n - base);
    summarize();
  end
endmodule
